/* hw/rpf_top.sv */
// Record path filter chain: three-coefficient filter, low/high-pass, stereo widening
`timescale 1ns/1ps
`default_nettype none
module rpf_top
   import rpf_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [8:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   output logic      [15:0] reg_rdata,
   input  wire rpf_sample_t in_sample,
   input  wire logic        in_valid,
   output logic             in_ready,
   output rpf_sample_t      out_sample,
   output logic             out_valid,
   input  wire logic        out_ready
);
   // Gain table, linear Q1.15, 0.375dB steps up to unity
   // Code 31 is unity, code 1 sits thirty steps down
   // Code zero is a true mute, not the floor value
   function automatic logic [15:0] gain_lin(input logic [4:0] code);
      logic [15:0] g;
      g = 16'h7FFF;
      // One step per code below the top
      // Rounding error grows by steps, well under 0.01dB
      for (int i = 31; i > 0; i--) begin
         if (code < 5'(i)) begin
            g = 16'((32'(g) * 32'h7A98) >> 15); // One 0.375dB step down
         end
      end
      if (code == 5'h00) begin
         g = 16'h0000;
      end
      return g;
   endfunction
   // Signed multiply by Q1.15 coefficient, saturated to 24 bits
   // Coefficient is zero-extended: spans zero to nearly two
   function automatic logic [23:0] mulq(input logic [23:0] x, input logic [15:0] c);
      logic signed [39:0] p;
      // Full-width product first, a narrow one loses top bits
      p = $signed(x) * $signed({1'b0, c});
      p = p >>> 15;
      return sat24(p[25:0]);
   endfunction
   // Clamp a 26-bit signed sum to the sample range
   // Clipping beats wrap-around, which turns a peak into a click
   function automatic logic [23:0] sat24(input logic [25:0] v);
      logic [23:0] r;
      r = v[23:0];
      if (v[25:23] != 3'b000 && v[25:23] != 3'b111) begin
         r = v[25] ? 24'h800000 : 24'h7FFFFF;
      end
      return r;
   endfunction
   // Full block state
   typedef struct packed {
      rpf_state_t  st;
      // Register images, unused bits held at zero
      logic [15:0] cap_ctrl;
      logic [15:0] cl0, cl1, cl2, cr0, cr1, cr2;
      logic [15:0] pass_ctrl, pass_coef;
      logic [15:0] wid_ctrl, wid_left, wid_coef, wid_right;
      logic [15:0] rdata;
      // Sample in flight and filter histories
      rpf_sample_t smp;
      rpf_sample_t cap_x1, cap_x2;
      rpf_sample_t pass_y;
      logic [23:0] wflt_y;
      logic [23:0] side_l, side_r;
      logic [RPF_DELAY_DEPTH*24-1:0] dl_l, dl_r;
      // Handshake flags toward FIFO and source
      logic        push;
      logic        in_rdy;
   } rpf_state_s_t;
   rpf_state_s_t s, next_s;
   // Output FIFO side
   logic         fifo_ready;
   logic         fifo_valid;
   rpf_sample_t  fifo_data;
   // Working values, all set at the top of the process
   rpf_sample_t  q;
   // Coefficients after the sharing choice
   logic [15:0]  kl0, kl1, kl2, kr0, kr1, kr2;
   logic [23:0]  a, b, mono, wside, tl, tr, dtl, dtr;
   logic [25:0]  accl, accr;
   // Next state: register writes and one sample through the chain
   always_comb begin
      next_s = s;
      next_s.push = 1'b0;
      q = s.smp;
      kl0 = s.cl0; kl1 = s.cl1; kl2 = s.cl2;
      kr0 = s.cr0; kr1 = s.cr1; kr2 = s.cr2;
      a = '0; b = '0; mono = '0; wside = '0; tl = '0; tr = '0; dtl = '0; dtr = '0;
      accl = '0; accr = '0;
      // Register write port
      // Unmapped indices fall to the default and change nothing
      // Unused control bits are stored as zero so they read zero
      if (reg_wr) begin
         unique case (reg_addr)
            RPF_ADDR_CAP_CTRL:    next_s.cap_ctrl  = {13'h0, reg_wdata[2:0]};
            RPF_ADDR_CAP_COEF_L0: next_s.cl0       = reg_wdata;
            RPF_ADDR_CAP_COEF_L1: next_s.cl1       = reg_wdata;
            RPF_ADDR_CAP_COEF_L2: next_s.cl2       = reg_wdata;
            RPF_ADDR_CAP_COEF_R0: next_s.cr0       = reg_wdata;
            RPF_ADDR_CAP_COEF_R1: next_s.cr1       = reg_wdata;
            RPF_ADDR_CAP_COEF_R2: next_s.cr2       = reg_wdata;
            RPF_ADDR_PASS_CTRL:   next_s.pass_ctrl = {14'h0, reg_wdata[1:0]};
            RPF_ADDR_PASS_COEF:   next_s.pass_coef = reg_wdata;
            RPF_ADDR_WID_CTRL:    next_s.wid_ctrl  = {9'h0, reg_wdata[6:4], 1'b0, reg_wdata[2:0]};
            RPF_ADDR_WID_LEFT:    next_s.wid_left  = {reg_wdata[15:2], 2'b00};
            RPF_ADDR_WID_COEF:    next_s.wid_coef  = reg_wdata;
            RPF_ADDR_WID_RIGHT:   next_s.wid_right = {reg_wdata[15:2], 2'b00};
            default: ;
         endcase
      end
      // Read port: data appears one cycle after the strobe, unmapped reads zero
      // A read beside a write to that index returns the old value
      if (reg_rd) begin
         unique case (reg_addr)
            RPF_ADDR_CAP_CTRL:    next_s.rdata = s.cap_ctrl;
            RPF_ADDR_CAP_COEF_L0: next_s.rdata = s.cl0;
            RPF_ADDR_CAP_COEF_L1: next_s.rdata = s.cl1;
            RPF_ADDR_CAP_COEF_L2: next_s.rdata = s.cl2;
            RPF_ADDR_CAP_COEF_R0: next_s.rdata = s.cr0;
            RPF_ADDR_CAP_COEF_R1: next_s.rdata = s.cr1;
            RPF_ADDR_CAP_COEF_R2: next_s.rdata = s.cr2;
            RPF_ADDR_PASS_CTRL:   next_s.rdata = s.pass_ctrl;
            RPF_ADDR_PASS_COEF:   next_s.rdata = s.pass_coef;
            RPF_ADDR_WID_CTRL:    next_s.rdata = s.wid_ctrl;
            RPF_ADDR_WID_LEFT:    next_s.rdata = s.wid_left;
            RPF_ADDR_WID_COEF:    next_s.rdata = s.wid_coef;
            RPF_ADDR_WID_RIGHT:   next_s.rdata = s.wid_right;
            default:              next_s.rdata = 16'h0000;
         endcase
      end
      // Coefficient sharing picks one set for both channels
      // Only coefficients swap; each channel keeps its own history
      if (s.cap_ctrl[RPF_SHARE_ON_BIT]) begin
         if (s.cap_ctrl[RPF_SHARE_SIDE_BIT]) begin
            kl0 = s.cr0; kl1 = s.cr1; kl2 = s.cr2;
         end else begin
            kr0 = s.cl0; kr1 = s.cl1; kr2 = s.cl2;
         end
      end
      // Each state is one stage; CAP, PASS and WIDEN take one cycle each, OUT waits for FIFO room so latency can vary
      unique case (s.st)
         RPF_ST_IDLE: begin
            // Ready rises here so a sample is taken next edge
            next_s.in_rdy = 1'b1;
            if (in_valid && s.in_rdy) begin
               next_s.smp    = in_sample;
               next_s.in_rdy = 1'b0;
               next_s.st     = RPF_ST_CAP;
            end
         end
         RPF_ST_CAP: begin
            // FIR over current and two past samples
            // Histories shift while off, so enabling starts clean
            // Three saturated terms fit in 26 bits before the clamp
            accl = 26'($signed(mulq(q.left, kl0))) + 26'($signed(mulq(s.cap_x1.left, kl1)))
                 + 26'($signed(mulq(s.cap_x2.left, kl2)));
            accr = 26'($signed(mulq(q.right, kr0))) + 26'($signed(mulq(s.cap_x1.right, kr1)))
                 + 26'($signed(mulq(s.cap_x2.right, kr2)));
            next_s.cap_x1 = q;
            next_s.cap_x2 = s.cap_x1;
            if (s.cap_ctrl[RPF_CAP_ON_BIT]) begin
               next_s.smp.left  = sat24(accl);
               next_s.smp.right = sat24(accr);
            end
            next_s.st = RPF_ST_PASS;
         end
         RPF_ST_PASS: begin
            // One-pole low-pass y += c*(x-y); high-pass is x minus that
            // Coefficient zero freezes the low-pass state
            // State is left alone while the stage is off
            a = sat24(26'($signed(s.pass_y.left)) + 26'($signed(mulq(
                sat24(26'($signed(q.left)) - 26'($signed(s.pass_y.left))), s.pass_coef))));
            b = sat24(26'($signed(s.pass_y.right)) + 26'($signed(mulq(
                sat24(26'($signed(q.right)) - 26'($signed(s.pass_y.right))), s.pass_coef))));
            if (s.pass_ctrl[RPF_PASS_ON_BIT]) begin
               next_s.pass_y.left  = a;
               next_s.pass_y.right = b;
               if (s.pass_ctrl[RPF_PASS_TYPE_BIT]) begin
                  next_s.smp.left  = sat24(26'($signed(q.left)) - 26'($signed(a)));
                  next_s.smp.right = sat24(26'($signed(q.right)) - 26'($signed(b)));
               end else begin
                  next_s.smp.left  = a;
                  next_s.smp.right = b;
               end
            end
            next_s.st = RPF_ST_WIDEN;
         end
         RPF_ST_WIDEN: begin
            // Side signal through its own filter, then per-channel delay
            // Half the channel difference cannot overflow
            // Delay lines shift every sample, even while off
            wside = sat24((26'($signed(q.left)) - 26'($signed(q.right))) >>> 1);
            a = sat24(26'($signed(s.wflt_y)) + 26'($signed(mulq(
                sat24(26'($signed(wside)) - 26'($signed(s.wflt_y))), s.wid_coef))));
            if (s.wid_ctrl[RPF_WFLT_ON_BIT]) begin
               next_s.wflt_y = a;
               wside = s.wid_ctrl[RPF_WFLT_TYPE_BIT] ? sat24(26'($signed(wside)) - 26'($signed(a))) : a;
            end
            next_s.dl_l = {s.dl_l[RPF_DELAY_DEPTH*24-25:0], wside};
            next_s.dl_r = {s.dl_r[RPF_DELAY_DEPTH*24-25:0], wside};
            // Reserved delay codes above eight clamp to the longest tap
            dtl = delay_tap(s.dl_l, wside, s.wid_left[RPF_DELAY_LSB +: 4]);
            dtr = delay_tap(s.dl_r, wside, s.wid_right[RPF_DELAY_LSB +: 4]);
            // Forward plus signed cross terms
            tl = mulq(q.left, gain_lin(s.wid_left[RPF_FWD_LSB +: 5]));
            tr = mulq(q.right, gain_lin(s.wid_right[RPF_FWD_LSB +: 5]));
            a  = mulq(dtl, gain_lin(s.wid_left[RPF_CROSS_LSB +: 5]));
            b  = mulq(dtr, gain_lin(s.wid_right[RPF_CROSS_LSB +: 5]));
            accl = s.wid_ctrl[RPF_POL_LEFT_BIT] ? 26'($signed(tl)) - 26'($signed(a))
                                                : 26'($signed(tl)) + 26'($signed(a));
            // A set polarity bit subtracts the cross term, clear adds it
            accr = s.wid_ctrl[RPF_POL_RIGHT_BIT] ? 26'($signed(tr)) - 26'($signed(b))
                                                 : 26'($signed(tr)) + 26'($signed(b));
            mono = sat24((26'($signed(q.left)) + 26'($signed(q.right))) >>> 1);
            if (s.wid_ctrl[RPF_WID_ON_BIT]) begin
               next_s.smp.left  = sat24(accl);
               next_s.smp.right = sat24(accr);
            end else if (s.wid_ctrl[RPF_MONO_BIT]) begin
               // Mono is ignored whenever the effect is on
               next_s.smp.left  = mono;
               next_s.smp.right = mono;
            end
            next_s.st = RPF_ST_OUT;
         end
         RPF_ST_OUT: begin
            // Wait for FIFO room; this back-pressure reaches the input
            // Ready stays low meanwhile, so no sample is lost
            // Push and ready rise together on one edge
            if (fifo_ready) begin
               next_s.push   = 1'b1;
               next_s.in_rdy = 1'b1;
               next_s.st     = RPF_ST_IDLE;
            end
         end
      endcase
   end
   // Select a delayed side sample; code zero is the current one
   // Tap n holds the side sample from n samples ago
   // Clamping keeps a reserved code harmless
   function automatic logic [23:0] delay_tap(input logic [RPF_DELAY_DEPTH*24-1:0] dl,
                                             input logic [23:0] cur, input logic [3:0] code);
      logic [3:0] c;
      c = (code > RPF_DELAY_MAX) ? RPF_DELAY_MAX : code;
      return (c == 4'h0) ? cur : dl[(32'(c) - 1) * 24 +: 24];
   endfunction
   // State register
   // Reset loads constants only; updates go through next_s
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         s       <= '0;
         s.st    <= RPF_ST_IDLE;
         s.rdata <= RPF_REG_RESET;
      end else begin
         s <= next_s;
      end
   end
   // Push holds the sample for one cycle into the FIFO
   // Eight words of slack let the sink pause briefly
   rpf_fifo #(
      .WIDTH ($bits(rpf_sample_t)),
      .DEPTH (RPF_FIFO_DEPTH)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .resetn    (resetn),
      .in_data   (s.smp),
      .in_valid  (s.push),
      .in_ready  (fifo_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (out_ready)
   );
   // Read data and input ready come from state flops
   assign reg_rdata  = s.rdata;
   assign in_ready   = s.in_rdy;
   // Output word and valid are the FIFO head
   assign out_sample = fifo_data;
   assign out_valid  = fifo_valid;
endmodule
`default_nettype wire

/* hw/rpf_pkg.sv */
// Shared constants and types for the record path filter and effects block
package rpf_pkg;
   // Register offsets (register index on the control port)
   localparam logic [8:0] RPF_ADDR_CAP_CTRL    = 9'h100;
   localparam logic [8:0] RPF_ADDR_CAP_COEF_L0 = 9'h101;
   localparam logic [8:0] RPF_ADDR_CAP_COEF_L1 = 9'h102;
   localparam logic [8:0] RPF_ADDR_CAP_COEF_L2 = 9'h103;
   localparam logic [8:0] RPF_ADDR_CAP_COEF_R0 = 9'h104;
   localparam logic [8:0] RPF_ADDR_CAP_COEF_R1 = 9'h105;
   localparam logic [8:0] RPF_ADDR_CAP_COEF_R2 = 9'h106;
   localparam logic [8:0] RPF_ADDR_PASS_CTRL   = 9'h108;
   localparam logic [8:0] RPF_ADDR_PASS_COEF   = 9'h109;
   localparam logic [8:0] RPF_ADDR_WID_CTRL    = 9'h10C;
   localparam logic [8:0] RPF_ADDR_WID_LEFT    = 9'h10D;
   localparam logic [8:0] RPF_ADDR_WID_COEF    = 9'h10E;
   localparam logic [8:0] RPF_ADDR_WID_RIGHT   = 9'h10F;
   // Field positions
   localparam int RPF_CAP_ON_BIT     = 0;
   localparam int RPF_SHARE_SIDE_BIT = 1;
   localparam int RPF_SHARE_ON_BIT   = 2;
   localparam int RPF_PASS_ON_BIT    = 0;
   localparam int RPF_PASS_TYPE_BIT  = 1;
   localparam int RPF_WID_ON_BIT     = 0;
   localparam int RPF_WFLT_ON_BIT    = 1;
   localparam int RPF_WFLT_TYPE_BIT  = 2;
   localparam int RPF_POL_RIGHT_BIT  = 4;
   localparam int RPF_POL_LEFT_BIT   = 5;
   localparam int RPF_MONO_BIT       = 6;
   localparam int RPF_FWD_LSB        = 11;
   localparam int RPF_CROSS_LSB      = 6;
   localparam int RPF_DELAY_LSB      = 2;
   // Reset value shared by every register
   localparam logic [15:0] RPF_REG_RESET = 16'h0000;
   // Delay line depth and top legal delay code
   localparam int          RPF_DELAY_DEPTH = 8;
   localparam logic [3:0]  RPF_DELAY_MAX   = 4'h8;
   // Sample FIFO depth
   localparam int          RPF_FIFO_DEPTH  = 8;
   // Stereo sample carrier
   typedef struct packed {
      logic [23:0] left;
      logic [23:0] right;
   } rpf_sample_t;
   // Processing state one-hot codes
   typedef enum logic [4:0] {
      RPF_ST_IDLE  = 5'h01,
      RPF_ST_CAP   = 5'h02,
      RPF_ST_PASS  = 5'h04,
      RPF_ST_WIDEN = 5'h08,
      RPF_ST_OUT   = 5'h10
   } rpf_state_t;
endpackage

/* hw/rpf_fifo.sv */
// Parameterised valid/ready FIFO for output samples
`timescale 1ns/1ps
`default_nettype none
module rpf_fifo #(
   parameter int WIDTH = 48,
   parameter int DEPTH = 8
) (
   input  wire logic             ref_clk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];   // Storage
   logic [AW-1:0]    wr_ptr;        // Write index
   logic [AW-1:0]    rd_ptr;        // Read index
   logic [AW:0]      count;         // Fill level
   logic             push;
   logic             pop;
   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   // Storage has no reset; only pointers and fill level need a defined value
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
   // Pointer and level tracking
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

/* tb/rpf_top_chk.sv */
// Port-level checker for the record path filter block
`timescale 1ns/1ps
`default_nettype none
module rpf_top_chk
   import rpf_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        resetn,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [8:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire rpf_sample_t in_sample,
   input wire logic        in_valid,
   input wire logic        in_ready,
   input wire rpf_sample_t out_sample,
   input wire logic        out_valid,
   input wire logic        out_ready
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // Readable bits per index; zero marks an unmapped index
   function automatic logic [15:0] rmask(input logic [8:0] a);
      case (a)
         RPF_ADDR_CAP_CTRL: return 16'h0007;
         RPF_ADDR_PASS_CTRL: return 16'h0003;
         RPF_ADDR_WID_CTRL: return 16'h0077;
         RPF_ADDR_WID_LEFT, RPF_ADDR_WID_RIGHT: return 16'hFFFC;
         RPF_ADDR_CAP_COEF_L0, RPF_ADDR_CAP_COEF_L1, RPF_ADDR_CAP_COEF_L2, RPF_ADDR_CAP_COEF_R0,
         RPF_ADDR_CAP_COEF_R1, RPF_ADDR_CAP_COEF_R2, RPF_ADDR_PASS_COEF, RPF_ADDR_WID_COEF: return 16'hFFFF;
         default: return 16'h0000;
      endcase
   endfunction
   // Steps of a sample through the chain and of a write followed by a read
   sequence s_take; in_valid && in_ready; endsequence
   sequence s_chain; s_take ##1 !in_ready [*4] ##1 in_ready; endsequence
   sequence s_wr_rd; reg_wr ##1 (reg_rd && !reg_wr && reg_addr == $past(reg_addr)); endsequence
   a_take_drops_ready: assert property (s_take |=> !in_ready [*3])
      else $error("input ready did not stay low after a take");
   a_push_shows_valid: assert property (s_chain |-> ##[0:1] out_valid)
      else $error("pushed sample not visible at output");
   a_out_word_stable: assert property (out_valid && !out_ready |=> $stable(out_sample))
      else $error("output word changed while stalled");
   a_out_valid_held: assert property (out_valid && !out_ready |=> out_valid)
      else $error("output valid dropped without a pop");
   a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");
   a_unmapped_zero: assert property (reg_rd && rmask(reg_addr) == 16'h0000 |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_unused_bits_zero: assert property (reg_rd |=> (reg_rdata & ~rmask($past(reg_addr))) == 16'h0000)
      else $error("unused register bits read nonzero");
   a_write_readback: assert property (s_wr_rd |=> reg_rdata == ($past(reg_wdata, 2) & rmask($past(reg_addr, 2))))
      else $error("register read back differs from write");
endmodule
bind rpf_top rpf_top_chk u_chk (
   .ref_clk(ref_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .in_sample(in_sample), .in_valid(in_valid),
   .in_ready(in_ready), .out_sample(out_sample), .out_valid(out_valid), .out_ready(out_ready)
);
`default_nettype wire

/* tb/rpf_sink.sv */
// Sink model standing in for the audio interface side of the record path
`timescale 1ns/1ps
`default_nettype none
module rpf_sink
   import rpf_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   input  wire logic        hold,       // Long stall so the FIFO can fill
   input  wire logic        slow,       // Accept only every other cycle
   input  wire logic        out_valid,
   input  wire rpf_sample_t out_sample,
   output logic             out_ready,
   output rpf_sample_t      last_word   // Most recent word taken
);
   logic [2:0] phase;                  // Free count that paces the slow mode
   // Ready moves just after the edge, like a real serialiser would
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         phase <= 3'h0;
         out_ready <= 1'b0;
         last_word <= '0;
      end else begin
         phase <= phase + 3'h1;
         out_ready <= !hold && !(slow && phase[0]);
         if (out_valid && out_ready) begin
            last_word <= out_sample;
         end
      end
   end
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the record path filter block
`timescale 1ns/1ps
`default_nettype none
module tb
   import rpf_pkg::*;
();
   logic        ref_clk, resetn, reg_wr, reg_rd, in_valid, out_ready, in_ready, out_valid, hold, slow;
   logic [8:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, d;
   logic [23:0] l, r;
   rpf_sample_t in_sample, out_sample, last_w;
   logic [47:0] exp_q [$];             // Expected output words, oldest first
   logic [31:0] rng = 32'h0000720B;    // Xorshift state
   int          n_fail = 0;
   int          checked = 0;
   logic [8:0]  regs [13] = '{RPF_ADDR_CAP_CTRL, RPF_ADDR_CAP_COEF_L0, RPF_ADDR_CAP_COEF_L1, RPF_ADDR_CAP_COEF_L2,
      RPF_ADDR_CAP_COEF_R0, RPF_ADDR_CAP_COEF_R1, RPF_ADDR_CAP_COEF_R2, RPF_ADDR_PASS_CTRL, RPF_ADDR_PASS_COEF,
      RPF_ADDR_WID_CTRL, RPF_ADDR_WID_LEFT, RPF_ADDR_WID_COEF, RPF_ADDR_WID_RIGHT};
   rpf_top DUT (.ref_clk(ref_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .in_sample(in_sample), .in_valid(in_valid),
      .in_ready(in_ready), .out_sample(out_sample), .out_valid(out_valid), .out_ready(out_ready));
   rpf_sink u_sink (.ref_clk(ref_clk), .resetn(resetn), .hold(hold), .slow(slow), .out_valid(out_valid),
      .out_sample(out_sample), .out_ready(out_ready), .last_word(last_w));
   always #25 ref_clk = ~ref_clk;
   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction
   // Readable bits of each register, written out apart from the checker's copy
   function automatic logic [15:0] rmask(input int i);
      case (i)
         0: return 16'h0007;
         7: return 16'h0003;
         9: return 16'h0077;
         10, 12: return 16'hFFFC;
         default: return 16'hFFFF;
      endcase
   endfunction
   // Mono mix of two signed samples; callers keep the sum even
   function automatic logic [23:0] avg(input logic [23:0] a, input logic [23:0] b);
      logic [24:0] s;
      s = {a[23], a} + {b[23], b};
      return s[24:1];
   endfunction
   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Waits for every expected word to leave; config changes only on an idle chain
   task automatic wait_idle();
      int k;
      k = 0;
      while (exp_q.size() != 0 && k < 500) begin
         @(negedge ref_clk);
         k++;
      end
      if (k >= 500) begin
         n_fail++;
         tally_and_finish();
      end
   endtask
   // One register cycle: optional write, then optional read of the same index
   task automatic acc(input logic [8:0] a, input logic [15:0] v, input logic w, input logic rd);
      wait_idle();
      @(posedge ref_clk);
      reg_wr <= w;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_rd <= rd;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
   endtask
   // Offers one sample, held until ready is seen high, and notes the expected word
   task automatic send(input logic [23:0] el, input logic [23:0] er);
      int k;
      exp_q.push_back({el, er});
      @(posedge ref_clk);
      in_sample <= {l, r};
      in_valid <= 1'b1;
      k = 0;
      do begin
         @(negedge ref_clk);
         k++;
      end while (in_ready !== 1'b1 && k < 200);
      if (k >= 200) begin
         n_fail++;
         tally_and_finish();
      end
      @(posedge ref_clk);
      in_valid <= 1'b0;
   endtask
   task automatic pick(input logic pair);
      l = 24'(xs());
      r = 24'(xs());
      r[0] = pair ? l[0] : r[0];
   endtask
   // Output watcher: every pop takes the oldest note
   always @(negedge ref_clk) begin
      if (out_valid === 1'b1 && out_ready === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk({47'h0, out_valid}, 48'h0);
         end else begin
            chk(out_sample, exp_q.pop_front());
         end
      end
   end
   initial begin
      ref_clk = 1'b0;
      resetn = 1'b0;
      {reg_wr, reg_rd, in_valid, hold, slow, reg_addr, reg_wdata, in_sample} = '0;
      repeat (8) @(posedge ref_clk);
      resetn <= 1'b1;
      slow <= 1'b1;
      foreach (regs[i]) begin
         acc(regs[i], 16'h0000, 1'b0, 1'b1);
         chk({32'h0, reg_rdata}, 48'h0);
      end
      foreach (regs[i]) begin
         d = 16'(xs());
         // Delay codes above eight are reserved, so keep to zero..seven
         if (i == 10 || i == 12) begin
            d[5] = 1'b0;
         end
         acc(regs[i], d, 1'b1, 1'b1);
         chk({32'h0, reg_rdata}, {32'h0, d & rmask(i)});
      end
      acc(9'h107, 16'hFFFF, 1'b1, 1'b1);
      chk({32'h0, reg_rdata}, 48'h0);
      foreach (regs[i]) acc(regs[i], 16'h0000, 1'b1, 1'b0);
      repeat (3) begin pick(1'b0); send(l, r); end
      acc(RPF_ADDR_WID_CTRL, 16'h0040, 1'b1, 1'b0);
      repeat (3) begin pick(1'b1); send(avg(l, r), avg(l, r)); end
      acc(RPF_ADDR_WID_CTRL, 16'h0041, 1'b1, 1'b0);
      pick(1'b1);
      send(24'h0, 24'h0);
      acc(RPF_ADDR_WID_CTRL, 16'h0071, 1'b1, 1'b0);
      pick(1'b0);
      send(24'h0, 24'h0);
      acc(RPF_ADDR_WID_LEFT, 16'h07C0, 1'b1, 1'b0);
      acc(RPF_ADDR_WID_RIGHT, 16'h07C0, 1'b1, 1'b0);
      acc(RPF_ADDR_WID_CTRL, 16'h0021, 1'b1, 1'b0);
      // Cross terms only at full gain: side is half the difference, signs opposite
      l = 24'h010000;
      r = 24'h000000;
      send(24'hFF8001, 24'h007FFF);
      acc(RPF_ADDR_WID_CTRL, 16'h0000, 1'b1, 1'b0);
      acc(RPF_ADDR_CAP_COEF_R0, 16'h8000, 1'b1, 1'b0);
      acc(RPF_ADDR_CAP_CTRL, 16'h0001, 1'b1, 1'b0);
      pick(1'b0);
      send(24'h0, r);
      acc(RPF_ADDR_CAP_CTRL, 16'h0005, 1'b1, 1'b0);
      pick(1'b0);
      send(24'h0, 24'h0);
      acc(RPF_ADDR_CAP_CTRL, 16'h0007, 1'b1, 1'b0);
      pick(1'b0);
      send(l, r);
      acc(RPF_ADDR_CAP_CTRL, 16'h0000, 1'b1, 1'b0);
      acc(RPF_ADDR_PASS_CTRL, 16'h0001, 1'b1, 1'b0);
      pick(1'b0);
      send(24'h0, 24'h0);
      acc(RPF_ADDR_PASS_CTRL, 16'h0003, 1'b1, 1'b0);
      pick(1'b0);
      send(l, r);
      acc(RPF_ADDR_PASS_CTRL, 16'h0000, 1'b1, 1'b0);
      @(posedge ref_clk);
      hold <= 1'b1;
      repeat (9) begin pick(1'b0); send(l, r); end
      repeat (10) @(negedge ref_clk);
      chk({47'h0, in_ready}, 48'h0);
      chk({47'h0, out_valid}, 48'h1);
      @(posedge ref_clk);
      hold <= 1'b0;
      wait_idle();
      @(negedge ref_clk);
      chk(last_w, {l, r});
      tally_and_finish();
   end
endmodule
`default_nettype wire
